// file: bench/ccs_far_side.sv
`timescale 1ns/1ps
// ------------------------------------
// Far side: measurement engine model
// ------------------------------------
module ccs_far_side (
  input  logic        core_clk,
  input  logic        rst_n,
  input  logic        busy_go,
  input  logic [7:0]  busy_len,
  input  logic        test_start,
  input  logic [15:0] code_set,
  output logic        ops_pending,
  output logic        test_done,
  output logic [15:0] test_code
);
  logic [7:0] busy_reg;
  logic [3:0] test_reg;
  // Code line carries junk outside its done pulse
  assign ops_pending = busy_reg != 8'h00;
  assign test_done = test_reg == 4'h1;
  assign test_code = test_done ? code_set : ~code_set;
  // Busy span and a deliberately slow self test
  always @(posedge core_clk) begin
    if (!rst_n) begin
      busy_reg <= 8'h00;
      test_reg <= 4'h0;
    end else begin
      busy_reg <= busy_go ? busy_len : busy_reg - {7'h00, ops_pending};
      test_reg <= test_start ? 4'hC : test_reg - {3'h0, |test_reg};
    end
  end
endmodule : ccs_far_side

// file: bench/ccs_monitor.sv
`timescale 1ns/1ps
// ------------------------------------
// Command unit port checker
// ------------------------------------
module ccs_monitor (
  input logic              core_clk,
  input logic              rst_n,
  input ccs_pkg::ccs_cmd_t cmd,
  input logic              cmd_valid,
  input logic              cmd_ready,
  input ccs_pkg::ccs_rsp_t rsp,
  input ccs_pkg::ccs_sub_t sub,
  input logic              ops_pending,
  input logic              trig_waiting,
  input logic              trig_src_bus,
  input logic              test_done,
  input logic [15:0]       test_code,
  input logic              status_clear,
  input logic              preset_pulse,
  input logic              meas_start
);
  import ccs_pkg::*;
  logic take;
  logic trig_ok;
  logic opc_wait;
  // Accepted command, armed trigger, completion query still open
  assign take = cmd_valid && cmd_ready;
  assign trig_ok = take && cmd.op == OP_BUS_TRIG && trig_waiting
    && trig_src_bus;
  assign opc_wait = !cmd_ready && cmd.op == OP_OP_COMPLETE && cmd.query
    && !rsp.valid;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_clear_pulse: assert property (
    take && cmd.op == OP_CLEAR_STATUS |=> status_clear)
    else $error("clear status pulse missing");
  a_opc_hold: assert property (
    opc_wait && ops_pending |=> !rsp.valid)
    else $error("completion reply too early");
  a_opc_reply: assert property (
    opc_wait && !ops_pending |=> rsp.valid && rsp.value == OPC_REPLY)
    else $error("completion reply missing or wrong");
  a_wait_block: assert property (
    take && cmd.op == OP_WAIT |=> !cmd_ready && !rsp.valid)
    else $error("wait did not block");
  a_preset_pulse: assert property (
    take && (cmd.op == OP_RESET || cmd.op == OP_PRESET) |=> preset_pulse)
    else $error("preset pulse missing");
  a_trig_gate: assert property (
    meas_start == $past(trig_ok))
    else $error("bus trigger gating wrong");
  a_test_reply: assert property (
    test_done && !cmd_ready |=> rsp.valid && rsp.value == $past(test_code))
    else $error("self test code not returned");
  a_sub_default: assert property (
    take && cmd.op == OP_SUBSYS && !cmd.suffix_given && !cmd.unit_given
    |=> sub.valid && sub.suffix == SUFFIX_DEF && sub.unit == UNIT_DEFAULT)
    else $error("subsystem defaults wrong");
  a_ident_reply: assert property (
    take && cmd.op == OP_IDENT |=> rsp.valid && rsp.kind == RSP_IDENT)
    else $error("identity reply missing");
  // Main scenarios reached
  c_opc: cover property (opc_wait && !ops_pending);
  c_trig: cover property (meas_start);
  c_test: cover property (test_done && !cmd_ready);
endmodule : ccs_monitor

bind ccs_unit ccs_monitor u_monitor (.core_clk, .rst_n, .cmd, .cmd_valid,
  .cmd_ready, .rsp, .sub, .ops_pending, .trig_waiting, .trig_src_bus,
  .test_done, .test_code, .status_clear, .preset_pulse, .meas_start);

// file: bench/common_command_status_unit_tb.sv
`timescale 1ns/1ps
module common_command_status_unit_tb;
  import ccs_pkg::*;
  // Arbitrary identity values
  localparam logic [15:0] ID_V = 16'h3C3C;
  localparam logic [15:0] FW_V = 16'h0102;
  logic core_clk, rst_n, cmd_valid, cmd_ready, err_push, ques_summary;
  logic oper_summary, trig_waiting, trig_src_bus, ops_pending, test_done;
  logic test_start, status_clear, preset_pulse, meas_start, recall_valid;
  logic individual_status_flag, service_request, busy_go;
  logic [7:0]  event_set, busy_len;
  logic [15:0] test_code, code_set, settings_now, recall_data, s;
  ccs_cmd_t    cmd, c;
  ccs_rsp_t    rsp;
  ccs_sub_t    sub;
  ccs_op_t     eop [3] = '{OP_EVT_ENABLE, OP_PPOLL_ENABLE, OP_SRQ_ENABLE};
  int num_errors, checks_done, seed, cyc, t, t0, r0, k;
  int n_rsp, n_clr, n_pre, n_meas, n_rcl;
  ccs_unit #(.IDENT_CODE(ID_V), .FW_VERSION(FW_V)) dut (.core_clk, .rst_n,
    .cmd, .cmd_valid, .cmd_ready, .rsp, .sub, .event_set, .err_push,
    .ques_summary, .oper_summary, .ops_pending, .trig_waiting,
    .trig_src_bus, .settings_now, .test_done, .test_code, .status_clear,
    .preset_pulse, .meas_start, .test_start, .recall_valid, .recall_data,
    .individual_status_flag, .service_request);
  ccs_far_side u_far (.core_clk, .rst_n, .busy_go, .busy_len, .test_start,
    .code_set, .ops_pending, .test_done, .test_code);
  // Clock, 5 ns period
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Pulse counters, read one negedge after the pulse
  always @(posedge core_clk) begin
    cyc++;
    n_rsp += rsp.valid;
    n_clr += status_clear;
    n_pre += preset_pulse;
    n_meas += meas_start;
    n_rcl += recall_valid;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  // operand travels in the param field
  function automatic ccs_cmd_t mk(ccs_op_t op, logic q, logic [15:0] p);
    mk = '0;
    mk.op = op;
    mk.query = q;
    mk.param = p;
  endfunction : mk
  // Status byte from its sources and masks
  function automatic logic [15:0] stb_exp(logic [7:0] standard_event_status, event_status_enable, service_request_enable,
                                          logic eq, qs, os);
    logic [7:0] b;
    b = {os, 1'b0, |(standard_event_status & event_status_enable), 1'b0, qs, eq, 2'b00};
    stb_exp = {8'h00, b | {1'b0, |(b & service_request_enable), 6'h00}};
  endfunction : stb_exp
  // Idle one edge, offer once ready, drop after the taking edge
  task automatic send(input ccs_cmd_t cc);
    int n;
    n = 0;
    // Keeps valid from falling and rising in one time step
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && n < 500) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= 500) begin
      num_errors++;
      report_and_stop();
    end
    cmd = cc;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask : send
  task automatic wait_rsp;
    t = 0;
    while (rsp.valid !== 1'b1 && t < 500) begin
      @(negedge core_clk);
      t++;
    end
    if (t >= 500) begin
      num_errors++;
      report_and_stop();
    end
  endtask : wait_rsp
  task automatic ask(input ccs_op_t op, input logic [15:0] exp);
    send(mk(op, 1'b1, 16'h0000));
    wait_rsp();
    check(rsp.value, exp);
  endtask : ask
  task automatic set(input ccs_op_t op, input logic [15:0] p);
    send(mk(op, 1'b0, p));
  endtask : set
  task automatic busy(input logic [7:0] n);
    busy_len = n;
    busy_go = 1'b1;
    @(negedge core_clk);
    busy_go = 1'b0;
  endtask : busy
  // ------------------------------------
  // Main sequence
  // ------------------------------------
  initial begin
    seed = 59;
    rst_n = 1'b0;
    cmd = '0;
    {cmd_valid, err_push, ques_summary, oper_summary} = 4'h0;
    {trig_waiting, trig_src_bus, busy_go, busy_len, event_set} = '0;
    {code_set, settings_now} = '0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    for (k = 0; k < 3; k++) begin
      ask(eop[k], 16'h0000);
      s = 16'($random(seed)) & REG_MAX;
      set(eop[k], s);
      ask(eop[k], s);
      set(eop[k], REG_MAX + 16'h0001);
      ask(eop[k], s);
    end
    ask(OP_EVT_READ, 16'h0010);
    s = 16'($random(seed)) & REG_MAX;
    event_set = s[7:0];
    @(negedge core_clk);
    event_set = 8'h00;
    ask(OP_EVT_READ, s);
    ask(OP_EVT_READ, 16'h0000);
    $display("enable and event tests done");
    set(OP_EVT_ENABLE, 16'h0001);
    set(OP_SRQ_ENABLE, 16'h0020);
    set(OP_PPOLL_ENABLE, 16'h0040);
    set(OP_OP_COMPLETE, 16'h0000);
    ask(OP_SUMMARY, stb_exp(1, 1, 8'h20, 0, 0, 0));
    check(service_request, 1'b1);
    check(individual_status_flag, 1'b1);
    ask(OP_IND_STATUS, 16'h0001);
    {err_push, ques_summary, oper_summary} = 3'h7;
    @(negedge core_clk);
    err_push = 1'b0;
    repeat (2) @(negedge core_clk);
    ask(OP_SUMMARY, stb_exp(1, 1, 8'h20, 1, 1, 1));
    {ques_summary, oper_summary} = 2'b00;
    r0 = n_clr;
    set(OP_CLEAR_STATUS, 16'h0000);
    ask(OP_SUMMARY, stb_exp(0, 1, 8'h20, 0, 0, 0));
    check(n_clr - r0, 1);
    ask(OP_EVT_ENABLE, 16'h0001);
    ask(OP_SRQ_ENABLE, 16'h0020);
    $display("status byte test done");
    busy(8'd20);
    t0 = cyc;
    ask(OP_OP_COMPLETE, OPC_REPLY);
    check(cyc - t0 >= 20, 1);
    busy(8'd10);
    t0 = cyc;
    r0 = n_rsp;
    set(OP_WAIT, 16'h0000);
    ask(OP_SRQ_ENABLE, 16'h0020);
    check(cyc - t0 >= 10, 1);
    @(negedge core_clk);
    check(n_rsp - r0, 1);
    $display("completion and wait tests done");
    s = 16'($random(seed));
    settings_now = s;
    set(OP_EVT_ENABLE, 16'h005A);
    set(OP_SAVE, SLOT_MAX);
    settings_now = ~s;
    set(OP_EVT_ENABLE, 16'h0000);
    r0 = n_rcl;
    set(OP_RECALL, SLOT_MAX);
    @(negedge core_clk);
    check(n_rcl - r0, 1);
    check(recall_data, s);
    ask(OP_EVT_ENABLE, 16'h005A);
    set(OP_SAVE, SLOT_MAX + 16'h0001);
    ask(OP_EVT_READ, 16'h0010);
    // Unknown operation flags an execution error
    set(OP_NONE, 16'h0000);
    ask(OP_EVT_READ, 16'h0010);
    for (k = 0; k < 2; k++) begin
      set(OP_EVT_ENABLE, 16'h00FF);
      r0 = n_pre;
      set(k == 0 ? OP_RESET : OP_PRESET, 16'h0000);
      @(negedge core_clk);
      check(n_pre - r0, 1);
      ask(OP_EVT_ENABLE, 16'h0000);
    end
    $display("save, recall and reset tests done");
    for (k = 0; k < 4; k++) begin
      {trig_src_bus, trig_waiting} = 2'(k);
      r0 = n_meas;
      set(OP_BUS_TRIG, 16'h0000);
      @(negedge core_clk);
      check(n_meas - r0, k == 3);
    end
    for (k = 0; k < 2; k++) begin
      code_set = k == 0 ? 16'h0000 : 16'($random(seed)) | 16'h0001;
      ask(OP_SELF_TEST, code_set);
    end
    for (k = 0; k < 3; k++) begin
      c = mk(OP_SUBSYS, k == 1, 16'($random(seed)));
      c.keyword = 8'($random(seed));
      c.long_form = k == 0;
      c.opt_omitted = k == 2;
      {c.suffix_given, c.suffix, c.unit_given, c.unit} =
        k == 2 ? 9'h17E : 9'h000;
      send(c);
      check({sub.valid, sub.keyword, sub.value},
            {1'b1, c.keyword, c.param});
      check(sub.suffix, k == 2 ? 4'h7 : SUFFIX_DEF);
      check(sub.unit, k == 2 ? 3'h6 : UNIT_DEFAULT);
    end
    send(mk(OP_IDENT, 1'b1, 16'h0000));
    wait_rsp();
    check({rsp.kind, rsp.value}, {RSP_IDENT, FW_V ^ ID_V});
    $display("trigger, test and parser tests done");
    report_and_stop();
  end
endmodule : common_command_status_unit_tb

// file: rtl/ccs_pkg.sv
package ccs_pkg;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int unsigned REG_W       = 8;
  localparam int unsigned PARAM_W     = 16;
  localparam int unsigned SUFFIX_W    = 4;
  localparam int unsigned UNIT_W      = 3;
  localparam int unsigned KEY_W       = 8;
  localparam int unsigned SLOT_W      = 4;
  localparam int unsigned ERRCNT_W    = 5;

  // Standard event register bit positions
  localparam int unsigned EVB_OPDONE  = 0;
  localparam int unsigned EVB_EXEERR  = 4;

  // Status summary byte bit positions
  localparam int unsigned SBB_ERRQ    = 2;
  localparam int unsigned SBB_QUES    = 3;
  localparam int unsigned SBB_EVSUM   = 5;
  localparam int unsigned SBB_RQS     = 6;
  localparam int unsigned SBB_OPER    = 7;

  // Reset values and fixed figures
  localparam logic [REG_W-1:0]    ENABLE_RST   = 8'h00;
  localparam logic [PARAM_W-1:0]  REG_MAX      = 16'h00FF;
  localparam logic [PARAM_W-1:0]  SLOT_MAX     = 16'h0009;
  localparam logic [SUFFIX_W-1:0] SUFFIX_DEF   = 4'h1;
  localparam logic [UNIT_W-1:0]   UNIT_DEFAULT = 3'h0;
  localparam logic [PARAM_W-1:0]  OPC_REPLY    = 16'h0001;

  // ----------------------------------------------------------------
  // Commands, replies, states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE, OP_CLEAR_STATUS, OP_EVT_ENABLE, OP_EVT_READ, OP_IDENT,
    OP_IND_STATUS, OP_OP_COMPLETE, OP_PPOLL_ENABLE, OP_RECALL,
    OP_RESET, OP_PRESET, OP_SAVE, OP_SRQ_ENABLE, OP_SUMMARY,
    OP_BUS_TRIG, OP_SELF_TEST, OP_WAIT, OP_SUBSYS
  } ccs_op_t;

  typedef enum logic [2:0] {
    RSP_NUMBER, RSP_IDENT
  } ccs_rsp_kind_t;

  typedef enum {
    ST_IDLE, ST_WAIT_DONE, ST_TEST
  } ccs_state_t;

  typedef struct packed {
    ccs_op_t               op;
    logic                  query;
    logic                  long_form;
    logic                  opt_omitted;
    logic [KEY_W-1:0]      keyword;
    logic                  suffix_given;
    logic [SUFFIX_W-1:0]   suffix;
    logic                  unit_given;
    logic [UNIT_W-1:0]     unit;
    logic [PARAM_W-1:0]    param;
  } ccs_cmd_t;

  typedef struct packed {
    logic                  valid;
    ccs_rsp_kind_t         kind;
    logic [PARAM_W-1:0]    value;
  } ccs_rsp_t;

  typedef struct packed {
    logic                  valid;
    logic                  query;
    logic [KEY_W-1:0]      keyword;
    logic [SUFFIX_W-1:0]   suffix;
    logic [UNIT_W-1:0]     unit;
    logic [PARAM_W-1:0]    value;
  } ccs_sub_t;

endpackage : ccs_pkg

// file: rtl/ccs_unit.sv
// Function
// - Clear status zeroes events and error queue
// - Clear status keeps the three enables
// - Event enable loads 0..255, resets 0
// - Event read returns register, then clears
// - Individual status query returns poll bit
// - Operation complete sets bit 0 when idle
// - Completion query waits, always answers 1
// - Wait blocks later commands until done
// - Poll enable loads 0..255, resets 0
// - Save stores state in slot 0..9
// - Recall restores state from slot 0..9
// - Reset restores defaults, same as preset
// - Request enable loads 0..255, resets 0
// - Summary query returns status byte
// - Bus trigger only when waiting and bus
// - Self test reports code, 0 passes
// - Missing suffix means suffix 1
// - Long, short, optional-omitted headers accepted
// - Unitless number takes default unit
// - Identification returns id with firmware
`timescale 1ns/1ps

module ccs_unit #(
  parameter int unsigned               SLOTS      = 10,
  parameter int unsigned               SET_W      = 16,
  parameter int unsigned               ERRQ_DEPTH = 16,
  // Arbitrary identification and firmware values
  parameter logic [15:0]               IDENT_CODE = 16'h0A5C,
  parameter logic [15:0]               FW_VERSION = 16'h0200
) (
  input  wire logic                    core_clk,
  input  wire logic                    rst_n,
  input  wire ccs_pkg::ccs_cmd_t       cmd,
  input  wire logic                    cmd_valid,
  output logic                         cmd_ready,
  output ccs_pkg::ccs_rsp_t            rsp,
  output ccs_pkg::ccs_sub_t            sub,
  input  wire logic [7:0]              event_set,
  input  wire logic                    err_push,
  input  wire logic                    ques_summary,
  input  wire logic                    oper_summary,
  input  wire logic                    ops_pending,
  input  wire logic                    trig_waiting,
  input  wire logic                    trig_src_bus,
  input  wire logic [SET_W-1:0]        settings_now,
  input  wire logic                    test_done,
  input  wire logic [15:0]             test_code,
  output logic                         status_clear,
  output logic                         preset_pulse,
  output logic                         meas_start,
  output logic                         test_start,
  output logic                         recall_valid,
  output logic [SET_W-1:0]             recall_data,
  output logic                         individual_status_flag,
  output logic                         service_request
);
  import ccs_pkg::*;

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  if (SLOTS < 10 || SLOTS > 16) begin : g_bad_slots
    $error("SLOTS must lie between 10 and 16");
  end
  if (ERRQ_DEPTH < 1 || ERRQ_DEPTH > 31) begin : g_bad_depth
    $error("ERRQ_DEPTH must lie between 1 and 31");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Parameter fits an 8-bit enable register
  function automatic logic fits_byte(input logic [PARAM_W-1:0] v);
    fits_byte = (v <= REG_MAX);
  endfunction : fits_byte

  // Parameter names an existing storage slot
  function automatic logic fits_slot(input logic [PARAM_W-1:0] v);
    fits_slot = (v <= SLOT_MAX);
  endfunction : fits_slot

  // Widen a byte into a reply value
  function automatic logic [PARAM_W-1:0] widen(input logic [7:0] v);
    widen = {8'h00, v};
  endfunction : widen

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam int unsigned SAVE_W = SET_W + 3 * REG_W;

  ccs_state_t              state_reg, state_next;
  ccs_op_t                 wait_op_reg, wait_op_next;
  logic [REG_W-1:0]        evt_enable_reg, evt_enable_next;
  logic [REG_W-1:0]        std_event_reg, std_event_next;
  logic [REG_W-1:0]        ppoll_enable_reg, ppoll_enable_next;
  logic [REG_W-1:0]        srq_enable_reg, srq_enable_next;
  logic [ERRCNT_W-1:0]     err_count_reg, err_count_next;
  logic [SAVE_W-1:0]       slot_mem [SLOTS];
  logic                    save_we;
  logic [SLOT_W-1:0]       save_idx;
  logic [SAVE_W-1:0]       recalled;
  logic                    ready_next;
  ccs_rsp_t                rsp_next;
  ccs_sub_t                sub_next;
  logic                    clear_next, preset_next, meas_next;
  logic                    test_next, recall_next;
  logic [SET_W-1:0]        recall_data_next;
  logic [REG_W-1:0]        summary;
  logic                    evt_summary, accept;

  // ----------------------------------------------------------------
  // Status summary byte
  // ----------------------------------------------------------------
  // Service bit follows masked summary; it never masks itself
  always_comb begin
    summary = '0;
    evt_summary = |(std_event_reg & evt_enable_reg);
    summary[SBB_ERRQ] = (err_count_reg != '0);
    summary[SBB_QUES] = ques_summary;
    summary[SBB_EVSUM] = evt_summary;
    summary[SBB_OPER] = oper_summary;
    summary[SBB_RQS] = |(summary & srq_enable_reg);
  end

  assign accept = cmd_valid && cmd_ready;
  assign recalled = slot_mem[cmd.param[SLOT_W-1:0]];

  // ----------------------------------------------------------------
  // Command execution
  // ----------------------------------------------------------------
  // Hardware event sets are applied last so they beat any clear
  always_comb begin
    state_next        = state_reg;
    wait_op_next      = wait_op_reg;
    evt_enable_next   = evt_enable_reg;
    std_event_next    = std_event_reg;
    ppoll_enable_next = ppoll_enable_reg;
    srq_enable_next   = srq_enable_reg;
    err_count_next    = err_count_reg;
    rsp_next          = '0;
    sub_next          = '0;
    clear_next        = 1'b0;
    preset_next       = 1'b0;
    meas_next         = 1'b0;
    test_next         = 1'b0;
    recall_next       = 1'b0;
    recall_data_next  = recall_data;
    save_we           = 1'b0;
    save_idx          = cmd.param[SLOT_W-1:0];
    case (state_reg)
      ST_IDLE: begin
        if (accept) begin
          case (cmd.op)
            OP_CLEAR_STATUS: begin
              std_event_next = '0;
              err_count_next = '0;
              clear_next     = 1'b1;
            end
            OP_EVT_ENABLE: begin
              if (cmd.query) begin
                rsp_next = '{1'b1, RSP_NUMBER, widen(evt_enable_reg)};
              end else if (fits_byte(cmd.param)) begin
                evt_enable_next = cmd.param[REG_W-1:0];
              end else begin
                std_event_next[EVB_EXEERR] = 1'b1;
              end
            end
            OP_EVT_READ: begin
              rsp_next = '{1'b1, RSP_NUMBER, widen(std_event_reg)};
              std_event_next = '0;
            end
            OP_IDENT: begin
              rsp_next = '{1'b1, RSP_IDENT, FW_VERSION ^ IDENT_CODE};
            end
            OP_IND_STATUS: begin
              rsp_next = '{1'b1, RSP_NUMBER,
                           widen({7'h00, individual_status_flag})};
            end
            OP_OP_COMPLETE, OP_WAIT: begin
              wait_op_next = cmd.op;
              state_next   = ST_WAIT_DONE;
            end
            OP_PPOLL_ENABLE: begin
              if (cmd.query) begin
                rsp_next = '{1'b1, RSP_NUMBER, widen(ppoll_enable_reg)};
              end else if (fits_byte(cmd.param)) begin
                ppoll_enable_next = cmd.param[REG_W-1:0];
              end else begin
                std_event_next[EVB_EXEERR] = 1'b1;
              end
            end
            OP_SAVE: begin
              if (fits_slot(cmd.param)) begin
                save_we = 1'b1;
              end else begin
                std_event_next[EVB_EXEERR] = 1'b1;
              end
            end
            OP_RECALL: begin
              if (fits_slot(cmd.param)) begin
                evt_enable_next   = recalled[SET_W +: REG_W];
                srq_enable_next   = recalled[SET_W+REG_W +: REG_W];
                ppoll_enable_next = recalled[SET_W+2*REG_W +: REG_W];
                recall_data_next  = recalled[SET_W-1:0];
                recall_next       = 1'b1;
              end else begin
                std_event_next[EVB_EXEERR] = 1'b1;
              end
            end
            OP_RESET, OP_PRESET: begin
              evt_enable_next   = ENABLE_RST;
              ppoll_enable_next = ENABLE_RST;
              srq_enable_next   = ENABLE_RST;
              preset_next       = 1'b1;
            end
            OP_SRQ_ENABLE: begin
              if (cmd.query) begin
                rsp_next = '{1'b1, RSP_NUMBER, widen(srq_enable_reg)};
              end else if (fits_byte(cmd.param)) begin
                srq_enable_next = cmd.param[REG_W-1:0];
              end else begin
                std_event_next[EVB_EXEERR] = 1'b1;
              end
            end
            OP_SUMMARY: begin
              rsp_next = '{1'b1, RSP_NUMBER, widen(summary)};
            end
            OP_BUS_TRIG: begin
              meas_next = trig_waiting && trig_src_bus;
            end
            OP_SELF_TEST: begin
              test_next  = 1'b1;
              state_next = ST_TEST;
            end
            OP_SUBSYS: begin
              sub_next.valid   = 1'b1;
              sub_next.query   = cmd.query;
              sub_next.keyword = cmd.keyword;
              sub_next.value   = cmd.param;
              sub_next.suffix  = cmd.suffix_given ? cmd.suffix : SUFFIX_DEF;
              sub_next.unit    = cmd.unit_given ? cmd.unit : UNIT_DEFAULT;
            end
            default: begin
              std_event_next[EVB_EXEERR] = 1'b1;
            end
          endcase
        end
      end
      ST_WAIT_DONE: begin
        // completion ends the message, so nothing queues behind
        if (!ops_pending) begin
          state_next = ST_IDLE;
          if (wait_op_reg == OP_OP_COMPLETE) begin
            if (cmd.query) begin
              rsp_next = '{1'b1, RSP_NUMBER, OPC_REPLY};
            end else begin
              std_event_next[EVB_OPDONE] = 1'b1;
            end
          end
        end
      end
      ST_TEST: begin
        if (test_done) begin
          rsp_next   = '{1'b1, RSP_NUMBER, test_code};
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Set wins over any clear in the same cycle
    std_event_next = std_event_next | event_set;
    if (err_push && (err_count_next < ERRCNT_W'(ERRQ_DEPTH))) begin
      err_count_next = err_count_next + 1'b1;
    end
    ready_next = (state_next == ST_IDLE);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Synchronous reset; the slot memory keeps its contents
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_reg              <= ST_IDLE;
      wait_op_reg            <= OP_NONE;
      evt_enable_reg         <= ENABLE_RST;
      std_event_reg          <= '0;
      ppoll_enable_reg       <= ENABLE_RST;
      srq_enable_reg         <= ENABLE_RST;
      err_count_reg          <= '0;
      cmd_ready              <= 1'b0;
      rsp                    <= '0;
      sub                    <= '0;
      status_clear           <= 1'b0;
      preset_pulse           <= 1'b0;
      meas_start             <= 1'b0;
      test_start             <= 1'b0;
      recall_valid           <= 1'b0;
      recall_data            <= '0;
      individual_status_flag <= 1'b0;
      service_request        <= 1'b0;
    end else begin
      state_reg              <= state_next;
      wait_op_reg            <= wait_op_next;
      evt_enable_reg         <= evt_enable_next;
      std_event_reg          <= std_event_next;
      ppoll_enable_reg       <= ppoll_enable_next;
      srq_enable_reg         <= srq_enable_next;
      err_count_reg          <= err_count_next;
      cmd_ready              <= ready_next;
      rsp                    <= rsp_next;
      sub                    <= sub_next;
      status_clear           <= clear_next;
      preset_pulse           <= preset_next;
      meas_start             <= meas_next;
      test_start             <= test_next;
      recall_valid           <= recall_next;
      recall_data            <= recall_data_next;
      individual_status_flag <= |(summary & ppoll_enable_reg);
      service_request        <= summary[SBB_RQS];
    end
  end

  // Slot storage; enables saved with the outside settings
  always_ff @(posedge core_clk) begin
    if (save_we) begin
      slot_mem[save_idx] <= {ppoll_enable_reg, srq_enable_reg,
                             evt_enable_reg, settings_now};
    end
  end

endmodule : ccs_unit
